/* File: aps_pkg.sv */
// Package for the serial protocol select block: modes, widths, counts.
// Assumes a 100 MHz system clock sampling the host's serial clock.
package aps_pkg;
  localparam int unsigned CMD_BITS      = 22;
  localparam int unsigned OUT_BITS      = 22;
  localparam int unsigned LANES         = 4;
  localparam int unsigned CNT_W         = 6;
  localparam logic [5:0]  CNT_MIN       = 6'h16;
  localparam logic [5:0]  CNT_SAT       = 6'h3F;
  localparam logic [21:0] CMD_RST       = 22'h000000;
  localparam logic [1:0]  IN_MODE_RST   = 2'h0;
  localparam logic [1:0]  LAUNCH_STD    = 2'h0;
  localparam logic [1:0]  LAUNCH_EARLY  = 2'h1;
  localparam logic [1:0]  LAUNCH_SRC    = 2'h3;
  localparam logic [1:0]  ECHO_EXT      = 2'h0;
  localparam logic [1:0]  WIDTH_SINGLE  = 2'h0;
  localparam logic [1:0]  WIDTH_DUAL    = 2'h2;
  localparam logic [1:0]  WIDTH_QUAD    = 2'h3;
  localparam int unsigned SRC_DIV       = 2;
  localparam logic [1:0]  SRC_DIV_LAST  = 2'(SRC_DIV - 1);

  typedef enum logic [1:0] {
    APS_IDLE  = 2'b00,
    APS_FRAME = 2'b01,
    APS_END   = 2'b10
  } aps_state_t;
endpackage

/* File: aps_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes inputs come from outside the system clock domain.
`timescale 1ns/100ps
module aps_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  // Pins
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

/* File: aps_core.sv */
// Serial host interface protocol select: input capture, output launch.
// Assumes a host master drives sclk/cs/sdi; output word from the converter.
// What this block does
// RL1 - Device-clocked output in zone two only supports external echo clock.
// RL2 - Without double rate, early launch drives each output bit half period before standard.
// RL3 - Device-clocked mode drives clock on ready strobe with output data.
// RL4 - Launch on one clock edge, capture on the opposite edge.
// RL5 - Input protocol values 0 to 3 choose polarity and capture edge.
// RL6 - After reset use idle-low rising-capture single-lane protocol.
// RL7 - Protocol change frame uses current protocol; later frames use new one.
// RL8 - Host gives at least 22 clocks per frame for a valid write.
// RL9 - Writes follow input protocol regardless of read protocol.
// RL10 - Wider bus, double rate and extended window may be combined.
// RL11 - Under 22 capture edges leaves input shift register unchanged.
// RL12 - Over 22 capture edges keeps the last 22 bits as command.
// RL13 - Early launch works only for input protocol 0 or 2.
// RL14 - Ready strobe held low for whole frame in compatible protocols.
// RL15 - Output lanes high impedance outside frames; driven only inside.
`timescale 1ns/100ps
module aps_core (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Host pins
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        sdi_in,
  // Configuration
  input  wire logic [1:0]  input_protocol_select_in,
  input  wire logic        input_protocol_load_in,
  input  wire logic [1:0]  output_launch_mode_in,
  input  wire logic [1:0]  echo_clock_source_select_in,
  input  wire logic [1:0]  output_width_in,
  input  wire logic        ddr_enable_in,
  input  wire logic        zone2_in,
  // Output word from the converter
  input  wire logic [21:0] out_word_in,
  // Serial output lanes and ready strobe
  output logic [3:0]       serial_output_lanes_out,
  output logic [3:0]       serial_output_lanes_oe_out,
  output logic             ready_strobe_pin_out,
  // Command and status
  output logic [21:0]      cmd_word_out,
  output logic             cmd_valid_out,
  output logic [1:0]       active_protocol_out,
  output logic             early_launch_out,
  output logic             src_mode_out,
  output logic             cfg_error_out
);
  logic [2:0]  pins_s;
  logic        sclk_s;
  logic        cs_n_s;
  logic        sdi_s;
  logic        sclk_d_ff;
  logic        cs_n_d_ff;
  logic [1:0]  mode_ff;
  logic [21:0] input_shift_register_ff;
  logic [21:0] shift_ff;
  logic [5:0]  cnt_ff;
  logic [21:0] out_ff;
  logic [3:0]  lanes_ff;
  logic [1:0]  div_ff;
  logic        rclk_ff;
  logic        cmd_valid_ff;
  aps_pkg::aps_state_t state_ff;
  logic        rise;
  logic        fall;
  logic        cap_edge;
  logic        lau_edge;
  logic        cs_fall;
  logic        cs_rise;
  logic        shift_edge;
  logic        early_launch;
  logic        src_mode;
  logic [2:0]  step;

  aps_sync #(.W(3)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({sclk_in, ~cs_n_in, sdi_in}),
    .sync_out   (pins_s)
  );
  // Select carried inverted so the synchroniser reset reads as idle
  assign sclk_s = pins_s[2];
  assign cs_n_s = ~pins_s[1];
  assign sdi_s  = pins_s[0];

  // Capture edge per mode: modes 0 and 3 rise, 1 and 2 fall
  function automatic logic capture_on_rise(input logic [1:0] m);
    capture_on_rise = (m == 2'h0) || (m == 2'h3);
  endfunction

  // Bits per launch edge from the output width alone
  function automatic logic [2:0] bits_per_edge(input logic [1:0] w);
    if (w == aps_pkg::WIDTH_QUAD)
      bits_per_edge = 3'h4;
    else if (w == aps_pkg::WIDTH_DUAL)
      bits_per_edge = 3'h2;
    else
      bits_per_edge = 3'h1;
  endfunction

  // Lane pattern for the top bits of a word
  function automatic logic [3:0] lane_bits(input logic [21:0] w,
                                           input logic [1:0]  wd);
    if (wd == aps_pkg::WIDTH_QUAD)
      lane_bits = w[21:18];
    else if (wd == aps_pkg::WIDTH_DUAL)
      lane_bits = {2'h0, w[21:20]};
    else
      lane_bits = {3'h0, w[21]};
  endfunction

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  assign rise    = sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign fall    = ~sclk_s & sclk_d_ff & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_n_d_ff;
  assign cs_rise = cs_n_s & ~cs_n_d_ff;
  // RL4 opposite edge launch
  assign cap_edge = capture_on_rise(mode_ff) ? rise : fall;
  assign lau_edge = (capture_on_rise(mode_ff) ? fall : rise) |
                    (ddr_enable_in & cap_edge);
  // RL13 early launch gating
  assign early_launch = (output_launch_mode_in == aps_pkg::LAUNCH_EARLY) &&
                        (mode_ff == 2'h0 || mode_ff == 2'h2);
  assign src_mode = (output_launch_mode_in == aps_pkg::LAUNCH_SRC);
  // RL10 combined width and rate
  assign step = bits_per_edge(output_width_in);

  // Frame tracking
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= aps_pkg::APS_IDLE;
    end else begin
      case (state_ff)
        aps_pkg::APS_IDLE:  if (cs_fall) state_ff <= aps_pkg::APS_FRAME;
        aps_pkg::APS_FRAME: if (cs_rise) state_ff <= aps_pkg::APS_END;
        default:            state_ff <= aps_pkg::APS_IDLE;
      endcase
    end
  end

  // RL9 capture per input protocol
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_ff <= aps_pkg::CMD_RST;
      cnt_ff   <= '0;
    end else if (cs_fall) begin
      cnt_ff <= '0;
    end else if (cap_edge) begin
      // RL12 keep last bits
      shift_ff <= {shift_ff[20:0], sdi_s};
      if (cnt_ff != aps_pkg::CNT_SAT)
        cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // RL11 short frame is no-op
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_shift_register_ff <= aps_pkg::CMD_RST;
      cmd_valid_ff            <= 1'b0;
    end else begin
      cmd_valid_ff <= 1'b0;
      if (cs_rise && cnt_ff >= aps_pkg::CNT_MIN) begin
        input_shift_register_ff <= shift_ff;
        cmd_valid_ff            <= 1'b1;
      end
    end
  end

  // RL6 reset protocol
  // RL7 new mode after frame end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      mode_ff <= aps_pkg::IN_MODE_RST;
    else if (input_protocol_load_in && state_ff == aps_pkg::APS_IDLE)
      mode_ff <= input_protocol_select_in;
  end

  // RL2 early shift edge
  assign shift_edge = (early_launch && !ddr_enable_in) ? cap_edge : lau_edge;

  // RL4 first bits at select fall for modes 0 and 2 only
  // Out register holds only the bits not yet shown on the lanes
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_ff   <= '0;
      lanes_ff <= '0;
    end else if (cs_fall) begin
      if (mode_ff[0]) begin
        out_ff   <= out_word_in;
        lanes_ff <= 4'h0;
      end else begin
        out_ff   <= 22'(out_word_in << step);
        lanes_ff <= lane_bits(out_word_in, output_width_in);
      end
    end else if (shift_edge) begin
      out_ff   <= 22'(out_ff << step);
      lanes_ff <= lane_bits(out_ff, output_width_in);
    end
  end

  // RL3 device clock on strobe
  // RL1 external echo in zone two
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_ff  <= '0;
      rclk_ff <= 1'b0;
    end else if (!src_mode || state_ff != aps_pkg::APS_FRAME) begin
      div_ff  <= '0;
      rclk_ff <= 1'b0;
    end else if (zone2_in &&
                 echo_clock_source_select_in == aps_pkg::ECHO_EXT) begin
      rclk_ff <= sclk_s;
    end else if (!zone2_in) begin
      div_ff <= (div_ff == aps_pkg::SRC_DIV_LAST) ? 2'h0 : div_ff + 2'h1;
      if (div_ff == aps_pkg::SRC_DIV_LAST)
        rclk_ff <= ~rclk_ff;
    end
  end

  assign cfg_error_out = src_mode && zone2_in &&
                         echo_clock_source_select_in != aps_pkg::ECHO_EXT;

  // RL15 lanes released outside frame
  always_comb begin
    serial_output_lanes_out    = lanes_ff;
    serial_output_lanes_oe_out = 4'h0;
    if (state_ff == aps_pkg::APS_FRAME && !cs_n_s) begin
      if (output_width_in == aps_pkg::WIDTH_QUAD)
        serial_output_lanes_oe_out = 4'hF;
      else if (output_width_in == aps_pkg::WIDTH_DUAL)
        serial_output_lanes_oe_out = 4'h3;
      else
        serial_output_lanes_oe_out = 4'h1;
    end
  end

  // RL14 strobe low in frame
  assign ready_strobe_pin_out = src_mode ? rclk_ff
                                : (state_ff == aps_pkg::APS_IDLE);
  assign cmd_word_out        = input_shift_register_ff;
  assign cmd_valid_out       = cmd_valid_ff;
  assign active_protocol_out = mode_ff;
  assign early_launch_out    = early_launch;
  assign src_mode_out        = src_mode;

  default clocking cb_a @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  short_nop_a: assert property ( // RL11
    (cs_rise && cnt_ff < aps_pkg::CNT_MIN) |=>
    !cmd_valid_out && $stable(cmd_word_out))
    else $error("short frame changed the command");
  long_keep_a: assert property ( // RL12
    (cs_rise && cnt_ff >= aps_pkg::CNT_MIN) |=>
    cmd_valid_out && cmd_word_out == $past(shift_ff))
    else $error("long frame did not keep the last bits");
  lanes_idle_a: assert property ( // RL15
    cs_n_s |-> serial_output_lanes_oe_out == 4'h0)
    else $error("lanes driven outside a frame");
  strobe_low_a: assert property ( // RL14
    (!src_mode && state_ff == aps_pkg::APS_FRAME) |->
    !ready_strobe_pin_out)
    else $error("strobe high inside a frame");
  early_gate_a: assert property ( // RL13
    mode_ff[0] |-> !early_launch_out)
    else $error("early launch in a late phase mode");
  mode_hold_a: assert property ( // RL7
    (state_ff != aps_pkg::APS_IDLE) |=> $stable(mode_ff))
    else $error("protocol changed inside a frame");
  cap_edge_a: assert property ( // RL5
    cap_edge |-> (capture_on_rise(mode_ff) ? sclk_s : !sclk_s))
    else $error("capture on the wrong clock edge");
  echo_clk_a: assert property ( // RL1
    (src_mode && zone2_in && state_ff == aps_pkg::APS_FRAME &&
     echo_clock_source_select_in == aps_pkg::ECHO_EXT) |=>
    ready_strobe_pin_out == $past(sclk_s))
    else $error("strobe does not echo the serial clock");
  early_hold_a: assert property ( // RL2
    (early_launch && !ddr_enable_in && lau_edge && !cs_fall) |=>
    $stable(serial_output_lanes_out))
    else $error("early launch shifted on a late edge");
endmodule

/* File: aps_host_model.sv */
// Host master model: drives serial clock, select and data frames.
// Assumes the bench calls frame() only while no frame is running.
`timescale 1ns/100ps
module aps_host_model (
  // Host pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  // Lanes from the device
  input  logic [3:0] sdo_in
);
  logic [63:0] rx;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
    rx       = 64'h0;
  end

  task automatic frame(input logic [1:0] mode, input int nbits,
                       input logic [63:0] word, input int s);
    rx = 64'h0;
    // Idle level settles well before select falls
    #2 sclk_out = mode[1];
    #62.5 cs_n_out = 1'b0;
    #62.5;
    for (int i = nbits - 1; i >= 0; i--) begin
      if (mode[0]) sclk_out = ~sclk_out;
      sdi_out = word[i];
      #62.5;
      // lanes taken just before own capture edge
      rx = (rx << s) | 64'(sdo_in & 4'((1 << s) - 1));
      sclk_out = ~sclk_out;
      #62.5;
      if (!mode[0]) sclk_out = ~sclk_out;
    end
    cs_n_out = 1'b1;
    // Released line: no stale bit left
    sdi_out = ~sdi_out;
  endtask
endmodule

/* File: test_adc_serial_protocol_select.sv */
// Testbench for the protocol select core: frames in all four modes.
// Assumes the host model is the only driver of the serial pins.
`timescale 1ns/100ps
module test_adc_serial_protocol_select;
  logic        sys_clk_in, rst_n_in, sclk, cs_n, sdi, load, ddr, zone2;
  logic        strobe, valid, early, src, cfg_err, chk_en;
  logic [1:0]  sel, launch, echo, width, cur, act;
  logic [3:0]  lanes, lanes_oe, cs_hist;
  logic [21:0] out_word, cmd_word, exp_word;
  int          err_total, checks, pulses, cycles, seed;

  aps_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
                         .sdo_in(lanes));

  aps_core i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .sdi_in(sdi), .input_protocol_select_in(sel),
    .input_protocol_load_in(load), .output_launch_mode_in(launch),
    .echo_clock_source_select_in(echo), .output_width_in(width),
    .ddr_enable_in(ddr), .zone2_in(zone2), .out_word_in(out_word),
    .serial_output_lanes_out(lanes), .serial_output_lanes_oe_out(lanes_oe),
    .ready_strobe_pin_out(strobe), .cmd_word_out(cmd_word),
    .cmd_valid_out(valid), .active_protocol_out(act),
    .early_launch_out(early), .src_mode_out(src), .cfg_error_out(cfg_err)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Host sees every group, or every other one at double rate
  function automatic logic [63:0] exp_rx(input logic [21:0] wd,
                                         input int          n,
                                         input logic [1:0]  wid,
                                         input logic        d);
    logic [127:0] v;
    logic [63:0]  r;
    int           s;
    s = (wid == 2'h3) ? 4 : ((wid == 2'h2) ? 2 : 1);
    v = {wd, 106'h0};
    r = 64'h0;
    for (int k = 0; k < n; k++) begin
      r = (r << s) | 64'(v >> (128 - s));
      v = v << (d ? 2 * s : s);
    end
    return r;
  endfunction

  task automatic results();
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cycle limit well above the roughly 5200 cycles needed
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  always @(posedge sys_clk_in) begin
    cs_hist <= {cs_hist[2:0], cs_n};
    if (valid === 1'b1) pulses++;
    if (chk_en) begin
      chk(early, launch == 2'h1 && !cur[0]);
      chk(src, launch == 2'h3);
      chk(cfg_err, launch == 2'h3 && zone2 && echo != 2'h0);
      // Device-clocked strobe rests low between frames
      if (cs_hist == 4'hF)
        chk({strobe, lanes_oe}, {launch != 2'h3, 4'h0});
      if (cs_hist == 4'h0 && launch != 2'h3) chk(strobe, 1'b0);
      if (cs_hist == 4'h0)
        chk(lanes_oe, width[1] ? {width[0], width[0], 2'h3} : 4'h1);
    end
  end

  task automatic run(input int nbits);
    logic [63:0] w;
    int          p0;
    int          s;
    @(posedge sys_clk_in);
    w = {$random(seed), $random(seed)};
    launch   <= w[1:0];
    echo     <= w[3:2];
    width    <= (w[5:4] == 2'h1) ? 2'h0 : w[5:4];
    ddr      <= w[6];
    zone2    <= w[7];
    out_word <= 22'($random(seed));
    p0 = pulses;
    repeat (2) @(posedge sys_clk_in);
    s = (width == 2'h3) ? 4 : ((width == 2'h2) ? 2 : 1);
    i_host.frame(cur, nbits, w, s);
    repeat (8) @(posedge sys_clk_in);
    if (nbits >= 22) exp_word = w[21:0];
    chk(pulses - p0, nbits >= 22);
    chk(cmd_word, exp_word);
    chk(i_host.rx, exp_rx(out_word, nbits, width, ddr));
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge sys_clk_in);
    chk_en <= 1'b0;
    sel    <= m;
    load   <= 1'b1;
    @(posedge sys_clk_in);
    load <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk(act, m);
    cur    <= m;
    chk_en <= 1'b1;
  endtask

  initial begin
    seed      = 5473;
    rst_n_in  = 1'b0;
    load      = 1'b0;
    sel       = 2'h0;
    launch    = 2'h0;
    echo      = 2'h0;
    width     = 2'h0;
    ddr       = 1'b0;
    zone2     = 1'b0;
    out_word  = 22'h000000;
    cur       = 2'h0;
    chk_en    = 1'b0;
    exp_word  = 22'h000000;
    err_total = 0;
    checks    = 0;
    pulses    = 0;
    cycles    = 0;
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk({act, cmd_word}, 24'h000000);
    chk_en <= 1'b1;
    for (int k = 1; k <= 4; k++) begin
      run(22);
      set_mode(2'(k));
      run(22);
      run(21);
      run(30);
    end
    results();
  end
endmodule
